// ===== src/rrs_map.svh
// Register offsets, field positions, reset values and timing figures of the regulator status block
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH

// Byte addresses on the APB side
`define RRS_SERVICE_OFS      8'h14
`define RRS_FLAGS_OFS        8'h18
`define RRS_CTRL_OFS         8'h1c
`define RRS_MASK_OFS         8'h20

// Event flag positions inside the event flag register
`define RRS_SLEEP_SYNC_BIT   0
`define RRS_DEEP_WAKE_BIT    1
`define RRS_LIGHT_WAKE_BIT   2
`define RRS_PERIODIC_BIT     3
`define RRS_EXT_WAKE_LSB     4
`define RRS_CAL_DONE_BIT     9
`define RRS_WATCHDOG_BIT     10
`define RRS_BUCK_READY_BIT   17
`define RRS_MEM_READY_BIT    18
`define RRS_RADIO_READY_BIT  19
`define RRS_EVENT_W          11
`define RRS_W1C_MASK         11'h2ff

// Regulator control register fields
`define RRS_CTRL_W           5
`define RRS_RADIO_EN_BIT     0
`define RRS_RADIO_FULL_BIT   1
`define RRS_MEM_EN_BIT       2
`define RRS_BUCK_EN_BIT      3
`define RRS_BUCK_BYPASS_BIT  4

`define RRS_FLAGS_RESET      11'h000
`define RRS_MASK_RESET       11'h000
`define RRS_CTRL_RESET       5'h00
`define RRS_SERVICE_WORD     32'hc0de5afe

// Warm-up times in microseconds and the clock rate in MHz
`define RRS_CLK_MHZ          100
`define RRS_RADIO_FULL_US    600
`define RRS_RADIO_SHORT_US   200
`define RRS_MEM_US           200
`define RRS_BUCK_REG_US      400
`define RRS_BUCK_BYPASS_US   700
`define RRS_CNT_W            17

`endif

// ===== src/rrs_pkg.sv
// Types shared by the regulator status block
`include "rrs_map.svh"

package rrs_pkg;

   typedef logic [3:0]            rrs_ext_wake_t;
   typedef logic [`RRS_CNT_W-1:0] rrs_count_t;

   typedef struct packed {
      logic [`RRS_EVENT_W-1:0] flags;
      logic [`RRS_EVENT_W-1:0] mask;
      logic [`RRS_CTRL_W-1:0]  ctrl;
      logic                    radio_mode_q;
      logic                    bypass_q;
      logic                    buck_fault;
      logic [31:0]             rdata;
      logic                    slverr;
      logic                    wd_restart;
      logic                    rtc_clear;
   } rrs_state_t;

   typedef struct packed {
      rrs_count_t cnt;
      logic       ready;
   } rrs_wu_state_t;

endpackage

// ===== src/rrs_wu_if.sv
// Link between the status block and one warm-up timer
`timescale 1ns/1ps
`default_nettype none

interface rrs_wu_if;
   import rrs_pkg::*;

   logic       start;
   rrs_count_t target;
   logic       ready;

   modport ctrl  (output start, output target, input ready);
   modport timer (input start, input target, output ready);
endinterface

`default_nettype wire

// ===== src/rrs_warmup.sv
// Warm-up timer for one regulator
`timescale 1ns/1ps
`default_nettype none

module rrs_warmup (
   input  wire logic clock,
   input  wire logic rst_n,
   rrs_wu_if.timer   wu
);
   import rrs_pkg::*;

   rrs_wu_state_t state_reg;
   rrs_wu_state_t state_next;

   // Reference clock count, restart on enable low
   always_comb begin
      state_next = state_reg;
      if (!wu.start) begin
         state_next.cnt   = '0;
         state_next.ready = 1'b0;
      end else if (!state_reg.ready) begin
         state_next.cnt = state_reg.cnt + rrs_count_t'(1);
         if (state_reg.cnt + rrs_count_t'(1) >= wu.target) begin
            state_next.ready = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wu.ready = state_reg.ready;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_restart_on_off: assert property (!wu.start |=> state_reg.cnt == '0 && !wu.ready)
      else $error("warm-up counter did not restart");
   chk_ready_at_target: assert property ($rose(wu.ready) |-> $past(state_reg.cnt) + 1 == $past(wu.target))
      else $error("ready rose at the wrong count");
endmodule

`default_nettype wire

// ===== src/rrs_top.sv
// Clock and reset manager event flags with regulator-ready status over APB
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rrs_map.svh"

module rrs_top #(
   parameter int RADIO_FULL_CYC  = `RRS_RADIO_FULL_US * `RRS_CLK_MHZ,
   parameter int RADIO_SHORT_CYC = `RRS_RADIO_SHORT_US * `RRS_CLK_MHZ,
   parameter int MEM_CYC         = `RRS_MEM_US * `RRS_CLK_MHZ,
   parameter int BUCK_REG_CYC    = `RRS_BUCK_REG_US * `RRS_CLK_MHZ,
   parameter int BUCK_BYPASS_CYC = `RRS_BUCK_BYPASS_US * `RRS_CLK_MHZ
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       irq,
   input  wire logic                  sleep_entry,
   input  wire logic                  sleep_sync_evt,
   input  wire logic                  deep_sleep_wake_evt,
   input  wire logic                  light_sleep_wake_evt,
   input  wire logic                  periodic_timer_evt,
   input  wire rrs_pkg::rrs_ext_wake_t external_wake_evt,
   input  wire logic                  cal_done_evt,
   input  wire logic                  watchdog_timeout,
   input  wire logic                  watchdog_irq_select,
   output logic                       watchdog_restart,
   output logic                       periodic_timer_clear,
   output logic                       radio_regulator_enable,
   output logic                       radio_full_path,
   output logic                       memory_regulator_enable,
   output logic                       buck_enable,
   output logic                       buck_bypass,
   output logic                       radio_regulator_ready,
   output logic                       memory_regulator_ready,
   output logic                       buck_ready
);
   import rrs_pkg::*;

   rrs_state_t state_reg;
   rrs_state_t state_next;

   logic                    setup_phase;
   logic                    wr_access;
   logic                    wr_flags;
   logic                    wr_ctrl;
   logic                    wr_mask;
   logic                    wr_service;
   logic                    service_ok;
   logic [`RRS_EVENT_W-1:0] set_vec;
   logic [`RRS_EVENT_W-1:0] clr_vec;
   logic [31:0]             flags_view;
   logic [2:0]              ready_raw;

   rrs_wu_if wu_radio ();
   rrs_wu_if wu_mem ();
   rrs_wu_if wu_buck ();

   assign setup_phase = psel && !penable;
   assign pready      = psel && penable;
   assign wr_access   = psel && penable && pwrite;
   assign wr_flags    = wr_access && paddr == `RRS_FLAGS_OFS;
   assign wr_ctrl     = wr_access && paddr == `RRS_CTRL_OFS;
   assign wr_mask     = wr_access && paddr == `RRS_MASK_OFS;
   assign wr_service  = wr_access && paddr == `RRS_SERVICE_OFS;
   assign service_ok  = wr_service && pwdata == `RRS_SERVICE_WORD;

   // Hardware events; bit 8 stays empty
   always_comb begin
      set_vec                          = '0;
      set_vec[`RRS_SLEEP_SYNC_BIT]     = sleep_sync_evt;
      set_vec[`RRS_DEEP_WAKE_BIT]      = deep_sleep_wake_evt;
      set_vec[`RRS_LIGHT_WAKE_BIT]     = light_sleep_wake_evt;
      set_vec[`RRS_PERIODIC_BIT]       = periodic_timer_evt;
      set_vec[`RRS_EXT_WAKE_LSB +: 4]  = external_wake_evt;
      set_vec[`RRS_CAL_DONE_BIT]       = cal_done_evt;
      // Time-out counts only in interrupt mode
      set_vec[`RRS_WATCHDOG_BIT]       = watchdog_timeout && watchdog_irq_select;
   end

   // Write-one clear on the clearable bits only
   always_comb begin
      clr_vec = '0;
      if (wr_flags) begin
         clr_vec = pwdata[`RRS_EVENT_W-1:0] & `RRS_W1C_MASK;
      end
      // Service word alone clears the watchdog flag
      clr_vec[`RRS_WATCHDOG_BIT] = service_ok;
   end

   always_comb begin
      flags_view                       = '0;
      flags_view[`RRS_EVENT_W-1:0]     = state_reg.flags;
      flags_view[`RRS_BUCK_READY_BIT]  = buck_ready;
      flags_view[`RRS_MEM_READY_BIT]   = memory_regulator_ready;
      flags_view[`RRS_RADIO_READY_BIT] = radio_regulator_ready;
   end

   always_comb begin
      state_next            = state_reg;
      state_next.wd_restart = service_ok;
      state_next.rtc_clear  = clr_vec[`RRS_PERIODIC_BIT];

      if (sleep_entry) begin
         state_next.flags = '0;
      end else begin
         // Set wins over a clear in the same cycle
         state_next.flags = (state_reg.flags & ~clr_vec) | set_vec;
      end

      if (wr_mask) begin
         state_next.mask = pwdata[`RRS_EVENT_W-1:0];
      end

      // Enables come from the control register
      if (wr_ctrl) begin
         state_next.ctrl = pwdata[`RRS_CTRL_W-1:0];
      end
      if (sleep_entry) begin
         state_next.ctrl = `RRS_CTRL_RESET;
      end
      state_next.radio_mode_q = state_reg.ctrl[`RRS_RADIO_FULL_BIT];
      state_next.bypass_q     = state_reg.ctrl[`RRS_BUCK_BYPASS_BIT];

      // Entering bypass with memory regulator on is forbidden
      if (!state_next.ctrl[`RRS_BUCK_EN_BIT] || !state_next.ctrl[`RRS_BUCK_BYPASS_BIT]) begin
         state_next.buck_fault = 1'b0;
      end
      if (state_next.ctrl[`RRS_BUCK_BYPASS_BIT] && !state_reg.ctrl[`RRS_BUCK_BYPASS_BIT]
          && (state_reg.ctrl[`RRS_MEM_EN_BIT] || state_next.ctrl[`RRS_MEM_EN_BIT])) begin
         state_next.buck_fault = 1'b1;
      end

      // Read data captured in setup, no flag side effects
      if (setup_phase) begin
         state_next.slverr = 1'b0;
         if (paddr == `RRS_FLAGS_OFS) begin
            state_next.rdata = flags_view;
         end else if (paddr == `RRS_CTRL_OFS) begin
            state_next.rdata = {27'h0, state_reg.ctrl};
         end else if (paddr == `RRS_MASK_OFS) begin
            state_next.rdata = {21'h0, state_reg.mask};
         end else if (paddr == `RRS_SERVICE_OFS) begin
            state_next.rdata = `RRS_SERVICE_WORD;
         end else begin
            state_next.rdata  = '0;
            state_next.slverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg       <= '0;
         state_reg.flags <= `RRS_FLAGS_RESET;
         state_reg.mask  <= `RRS_MASK_RESET;
         state_reg.ctrl  <= `RRS_CTRL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Radio target follows the path selection
   assign wu_radio.target = state_reg.ctrl[`RRS_RADIO_FULL_BIT] ? rrs_count_t'(RADIO_FULL_CYC)
                                                                : rrs_count_t'(RADIO_SHORT_CYC);
   assign wu_mem.target   = rrs_count_t'(MEM_CYC);
   assign wu_buck.target  = state_reg.ctrl[`RRS_BUCK_BYPASS_BIT] ? rrs_count_t'(BUCK_BYPASS_CYC)
                                                                 : rrs_count_t'(BUCK_REG_CYC);

   // A mode change restarts the warm-up as a drop of enable would
   assign wu_radio.start = state_reg.ctrl[`RRS_RADIO_EN_BIT]
                           && state_reg.ctrl[`RRS_RADIO_FULL_BIT] == state_reg.radio_mode_q;
   assign wu_mem.start   = state_reg.ctrl[`RRS_MEM_EN_BIT];
   assign wu_buck.start  = state_reg.ctrl[`RRS_BUCK_EN_BIT] && !state_reg.buck_fault
                           && state_reg.ctrl[`RRS_BUCK_BYPASS_BIT] == state_reg.bypass_q;

   rrs_warmup u_radio_warmup (
      .clock (clock),
      .rst_n (rst_n),
      .wu    (wu_radio.timer)
   );

   rrs_warmup u_mem_warmup (
      .clock (clock),
      .rst_n (rst_n),
      .wu    (wu_mem.timer)
   );

   rrs_warmup u_buck_warmup (
      .clock (clock),
      .rst_n (rst_n),
      .wu    (wu_buck.timer)
   );

   assign ready_raw = {wu_radio.ready, wu_mem.ready, wu_buck.ready};

   // Ready flags straight from the timers
   assign radio_regulator_ready  = ready_raw[2];
   assign memory_regulator_ready = ready_raw[1];
   // Fault masks buck ready at once, not a cycle late
   assign buck_ready             = ready_raw[0] && !state_reg.buck_fault;

   // Only the event bits reach the interrupt
   assign irq = |(state_reg.flags & state_reg.mask);

   assign prdata                  = state_reg.rdata;
   assign pslverr                 = state_reg.slverr && pready;
   // Pulse toward the slow timer; local flag clears on the same edge that raises it
   assign periodic_timer_clear    = state_reg.rtc_clear;
   assign watchdog_restart        = state_reg.wd_restart;
   assign radio_regulator_enable  = state_reg.ctrl[`RRS_RADIO_EN_BIT];
   assign radio_full_path         = state_reg.ctrl[`RRS_RADIO_FULL_BIT];
   assign memory_regulator_enable = state_reg.ctrl[`RRS_MEM_EN_BIT];
   assign buck_enable             = state_reg.ctrl[`RRS_BUCK_EN_BIT];
   assign buck_bypass             = state_reg.ctrl[`RRS_BUCK_BYPASS_BIT];

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_read_keeps_flags: assert property (
      psel && !pwrite && !sleep_entry && set_vec == '0 && !service_ok |=> $stable(state_reg.flags))
      else $error("flag changed without cause");

   chk_w1c_sleep_sync: assert property (
      wr_flags && pwdata[0] && !sleep_sync_evt |=> !state_reg.flags[`RRS_SLEEP_SYNC_BIT])
      else $error("write one did not clear bit 0");

   chk_w1c_event_wins: assert property (
      wr_flags && pwdata[`RRS_EXT_WAKE_LSB] && external_wake_evt[0] && !sleep_entry
      |=> state_reg.flags[`RRS_EXT_WAKE_LSB])
      else $error("event lost against a clear");

   chk_sleep_clears_all: assert property (sleep_entry |=> state_reg.flags == '0 && state_reg.ctrl == '0 ##1
      !radio_regulator_ready && !memory_regulator_ready && !buck_ready)
      else $error("contents survived sleep");

   chk_radio_needs_en: assert property (radio_regulator_ready |-> $past(radio_regulator_enable))
      else $error("radio ready without enable");

   chk_radio_target: assert property (
      wu_radio.target == (radio_full_path ? RADIO_FULL_CYC : RADIO_SHORT_CYC))
      else $error("radio warm-up target wrong");

   chk_mem_off_clears: assert property (!memory_regulator_enable |=> !memory_regulator_ready)
      else $error("memory ready while disabled");

   chk_buck_target: assert property (
      wu_buck.target == (buck_bypass ? BUCK_BYPASS_CYC : BUCK_REG_CYC))
      else $error("buck warm-up target wrong");

   chk_irq_events_only: assert property (irq == |(flags_view[`RRS_EVENT_W-1:0] & state_reg.mask))
      else $error("interrupt does not follow events");

   chk_bypass_fault: assert property (
      $rose(buck_bypass) && $past(memory_regulator_enable) |-> !buck_ready throughout buck_bypass[*3])
      else $error("buck ready after forbidden bypass");

   chk_reserved_zero: assert property (
      $past(setup_phase) && $past(paddr) == `RRS_FLAGS_OFS |-> prdata[31:20] == '0 && prdata[16:11] == '0)
      else $error("reserved bits not zero");

   chk_wdog_sticky: assert property (
      state_reg.flags[`RRS_WATCHDOG_BIT] && !service_ok && !sleep_entry
      |=> state_reg.flags[`RRS_WATCHDOG_BIT])
      else $error("watchdog flag cleared without service");

   chk_cal_done_sets: assert property (cal_done_evt && !sleep_entry |=> state_reg.flags[`RRS_CAL_DONE_BIT])
      else $error("calibration flag missed");

   chk_periodic_clear: assert property (
      wr_flags && pwdata[`RRS_PERIODIC_BIT] && !periodic_timer_evt
      |-> ##[1:2] !state_reg.flags[`RRS_PERIODIC_BIT])
      else $error("periodic flag clear too slow");
endmodule

`default_nettype wire

// ===== dv/regulator_ready_status_test.sv
// Self-checking bench for the regulator status block
`timescale 1ns/1ps
`default_nettype none
`include "rrs_map.svh"

module regulator_ready_status_test;
   import rrs_pkg::*;
   localparam int T_RF = 20;
   localparam int T_RS = 8;
   localparam int T_M  = 8;
   localparam int T_BR = 12;
   localparam int T_BB = 16;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        sleep_entry = 1'b0;
   logic        watchdog_irq_select = 1'b1;
   logic [10:0] evt_v = 11'h000;
   wire logic   sleep_sync_evt, deep_sleep_wake_evt, light_sleep_wake_evt, periodic_timer_evt, cal_done_evt;
   wire logic   watchdog_timeout;
   wire rrs_ext_wake_t external_wake_evt;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, watchdog_restart, periodic_timer_clear;
   logic        radio_regulator_enable, radio_full_path, memory_regulator_enable, buck_enable, buck_bypass;
   logic        radio_regulator_ready, memory_regulator_ready, buck_ready;
   logic [10:0] mflags = 11'h000;
   logic [2:0]  mrdy = 3'b000;
   int          n_errors = 0;
   int          n_compared = 0;
   int          n_pclr = 0;
   int          n_wdr = 0;
   int          exp_pclr = 0;
   int          exp_wdr = 0;
   logic [31:0] r;
   logic        e;
   logic [4:0]  wc [5] = '{5'h01, 5'h03, 5'h04, 5'h08, 5'h18};
   int          wk [5] = '{2, 2, 1, 0, 0};
   int          wt [5] = '{T_RS, T_RF, T_M, T_BR, T_BB};

   // Bit 8 of the event vector has no source
   assign {watchdog_timeout, cal_done_evt} = evt_v[10:9];
   assign external_wake_evt = evt_v[7:4];
   assign {periodic_timer_evt, light_sleep_wake_evt, deep_sleep_wake_evt, sleep_sync_evt} = evt_v[3:0];

   rrs_top #(.RADIO_FULL_CYC(T_RF), .RADIO_SHORT_CYC(T_RS), .MEM_CYC(T_M), .BUCK_REG_CYC(T_BR),
             .BUCK_BYPASS_CYC(T_BB)) uut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .sleep_entry(sleep_entry), .sleep_sync_evt(sleep_sync_evt), .deep_sleep_wake_evt(deep_sleep_wake_evt),
      .light_sleep_wake_evt(light_sleep_wake_evt), .periodic_timer_evt(periodic_timer_evt),
      .external_wake_evt(external_wake_evt), .cal_done_evt(cal_done_evt), .watchdog_timeout(watchdog_timeout),
      .watchdog_irq_select(watchdog_irq_select), .watchdog_restart(watchdog_restart),
      .periodic_timer_clear(periodic_timer_clear), .radio_regulator_enable(radio_regulator_enable),
      .radio_full_path(radio_full_path), .memory_regulator_enable(memory_regulator_enable),
      .buck_enable(buck_enable), .buck_bypass(buck_bypass), .radio_regulator_ready(radio_regulator_ready),
      .memory_regulator_ready(memory_regulator_ready), .buck_ready(buck_ready));

   always #5 clock = ~clock;

   always @(posedge clock) begin
      if (periodic_timer_clear === 1'b1) n_pclr++;
      if (watchdog_restart === 1'b1) n_wdr++;
   end

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask

   // Holds the request until pready is sampled high, bounded
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_errors++;
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        y;
      apb(1'b1, a, d, x, y);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] x;
      logic        y;
      apb(1'b0, a, 32'h0, x, y);
      chk(name, exp, x);
   endtask

   function automatic logic [31:0] exp_flags();
      return {12'h000, mrdy[2], mrdy[1], mrdy[0], 6'h00, mflags};
   endfunction

   task automatic wflags(input logic [31:0] d);
      wr(`RRS_FLAGS_OFS, d);
      mflags &= ~(d[10:0] & `RRS_W1C_MASK);
      if (d[3]) exp_pclr++;
   endtask

   task automatic evt(input logic [10:0] v);
      @(posedge clock);
      evt_v <= v;
      @(posedge clock);
      evt_v <= 11'h000;
      mflags |= v & (watchdog_irq_select ? 11'h6ff : 11'h2ff);
   endtask

   function automatic logic rdy(input int k);
      return (k == 0) ? buck_ready : (k == 1) ? memory_regulator_ready : radio_regulator_ready;
   endfunction

   task automatic measure(input int k, input int t);
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge clock);
         if (rdy(k) === 1'b1) break;
      end
      chk("warm-up in window", 32'h1, {31'h0, i >= t && i <= t + 3});
      mrdy[k] = 1'b1;
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "ready flag");
   endtask

   initial begin
      void'($urandom(32'h06c9));
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(`RRS_FLAGS_OFS, 32'h0, "flags reset");
      rd_chk(`RRS_CTRL_OFS, 32'h0, "control reset");
      apb(1'b0, 8'h00, 32'h0, r, e);
      chk("unmapped data", 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, e});
      $display("test reset and map done");
      for (int idx = 0; idx < 11; idx++) begin
         evt(11'(1 << idx));
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "event set");
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "read again");
         wflags(32'h0);
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "zero write");
         wflags(32'h1 << idx);
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "one write");
      end
      wr(`RRS_SERVICE_OFS, 32'h12345678);
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "wrong service");
      wr(`RRS_SERVICE_OFS, `RRS_SERVICE_WORD);
      exp_wdr++;
      mflags[10] = 1'b0;
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "service clear");
      watchdog_irq_select <= 1'b0;
      evt(11'h400);
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "reset mode timeout");
      watchdog_irq_select <= 1'b1;
      repeat (6) begin
         evt(11'($urandom));
         wflags($urandom);
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "random clear");
      end
      $display("test event flags done");
      for (int j = 0; j < 5; j++) begin
         wr(`RRS_CTRL_OFS, {27'h0, wc[j]});
         measure(wk[j], wt[j]);
         wr(`RRS_CTRL_OFS, 32'h0);
         mrdy = 3'b000;
         rd_chk(`RRS_FLAGS_OFS, exp_flags(), "ready drops");
      end
      wr(`RRS_CTRL_OFS, 32'h1);
      repeat (3) @(posedge clock);
      wr(`RRS_CTRL_OFS, 32'h0);
      wr(`RRS_CTRL_OFS, 32'h1);
      measure(2, T_RS);
      wr(`RRS_CTRL_OFS, 32'h0);
      mrdy = 3'b000;
      $display("test warm-up done");
      // Random events may have left flags set; the interrupt check needs them clear
      wflags(32'h2ff);
      wr(`RRS_SERVICE_OFS, `RRS_SERVICE_WORD);
      exp_wdr++;
      mflags = 11'h000;
      wr(`RRS_CTRL_OFS, 32'h0c);
      // Memory warm-up is shorter than buck regulation, so it is ready first
      mrdy[1] = 1'b1;
      measure(0, T_BR);
      wr(`RRS_MASK_OFS, 32'h7ff);
      @(negedge clock);
      chk("irq ready only", 32'h0, {31'h0, irq});
      wr(`RRS_CTRL_OFS, 32'h1c);
      mrdy[0] = 1'b0;
      repeat (T_BB + 6) begin
         @(posedge clock);
         if (buck_ready !== 1'b0) chk("buck fault", 32'h0, {31'h0, buck_ready});
      end
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "fault flag");
      wr(`RRS_CTRL_OFS, 32'h0);
      mrdy = 3'b000;
      // Memory regulator off, bypass established, then memory on
      wr(`RRS_CTRL_OFS, 32'h18);
      measure(0, T_BB);
      wr(`RRS_CTRL_OFS, 32'h1c);
      measure(1, T_M);
      chk("buck kept", 32'h1, {31'h0, buck_ready});
      $display("test buck bypass done");
      evt(11'h010);
      @(negedge clock);
      chk("irq set", 32'h1, {31'h0, irq});
      wr(`RRS_MASK_OFS, 32'h0);
      @(negedge clock);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`RRS_MASK_OFS, 32'h7ff);
      @(negedge clock);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wflags(32'h10);
      @(negedge clock);
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test interrupt done");
      evt(11'h2ff);
      @(posedge clock);
      sleep_entry <= 1'b1;
      @(posedge clock);
      sleep_entry <= 1'b0;
      mflags = 11'h000;
      mrdy = 3'b000;
      rd_chk(`RRS_FLAGS_OFS, exp_flags(), "sleep flags");
      rd_chk(`RRS_CTRL_OFS, 32'h0, "sleep control");
      wr(`RRS_CTRL_OFS, 32'h05);
      evt(11'h0ff);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      mflags = 11'h000;
      rd_chk(`RRS_FLAGS_OFS, 32'h0, "reset flags");
      rd_chk(`RRS_CTRL_OFS, 32'h0, "reset control");
      chk("clear pulses", exp_pclr, n_pclr);
      chk("restart pulses", exp_wdr, n_wdr);
      $display("test sleep and reset done");
      complete_run();
   end
endmodule

`default_nettype wire
